// *** logic/sfxr_top.sv ***
// SPI flash memory-mapped read engine with flash management sequencer
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "sfxr_cfg.svh"

// Overview of operation
// - Mapped window reads become flash read transactions
// - Command phase sends the opcode field
// - Opcode lane width 00 uses one line
// - Address lane width 10 uses four lines
// - Option lane width 10 uses four lines
// - Read lane width 10 samples four lines
// - Dummy enable inserts dummy phase before data
// - Command enable emits the command phase
// - Second opcode omitted when its enable clear
// - Address byte select 0111 sends 24 bits
// - Option select 1000 sends top byte only
// - Dummy lane width 00 means single-line cycles
// - Dummy count 101 gives six cycles
// - Rate 01, divider 00 halves the clock
// - Flash register writes only in direct mode
// - Write enable precedes every status write
// - Setup sets quad bit 6 and config bit 7
// - Wait for ready after erase
// - Busy end found by repeated status reads
// - Setup clears all four protection bits
// - Sector erase then ready wait
module sfxr_top import sfxr_pkg::*; (
   input  wire logic        i_sys_clk,    // System clock, 200 MHz
   input  wire logic        i_sys_rst,    // Async reset, active high
   input  wire logic [7:0]  i_reg_addr,   // Register byte address
   input  wire logic [31:0] i_reg_wdata,  // Register write data
   input  wire logic        i_reg_wr,     // Register write strobe
   input  wire logic        i_reg_rd,     // Register read strobe
   output logic      [31:0] o_reg_rdata,  // Read data, cycle after strobe
   input  wire logic        i_mem_rd,     // Mapped window read request
   input  wire logic [31:0] i_mem_addr,   // Mapped window byte address
   output logic             o_mem_ready,  // A request would be taken
   output logic      [31:0] o_mem_rdata,  // Word read from flash
   output logic             o_mem_valid,  // Word valid pulse
   output logic             o_spi_sclk,   // Serial clock
   output logic             o_spi_cs_n,   // Chip select, active low
   output logic      [3:0]  o_spi_io_out, // Data lanes out
   output logic      [3:0]  o_spi_io_oe,  // Data lane drive enables
   input  wire logic [3:0]  i_spi_io_in   // Data lanes in
);

   sfxr_state_type st_ff;
   sfxr_state_type nxt_st;
   sfxr_ena_type   en_r;
   logic [7:0]     opc_seq;
   logic           x;
   logic           d_addr;
   logic           d_read;
   logic           d_wr;
   logic           go_mem;
   logic           start;
   logic           fall;
   logic           rd_ph;
   logic           drive;
   logic [2:0]     cur;
   logic [2:0]     np;
   logic [6:0]     en;
   logic [1:0]     lw [7];
   logic [2:0]     nb [7];
   logic [31:0]    ld [7];
   logic [31:0]    m;
   logic [31:0]    sh;
   logic [3:0]     inb;
   logic [1:0]     wn;
   logic [7:0]     rv;
   logic [13:0]    half;

   function automatic logic [2:0] pc4(input logic [3:0] v);
      pc4 = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
   endfunction

   function automatic logic [1:0] lsh(input logic [1:0] w);
      lsh = w[1] ? 2'd2 : (w[0] ? 2'd1 : 2'd0);
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.mem_valid = 1'b0;
      nxt_st.sync1 = i_spi_io_in;
      nxt_st.sync2 = st_ff.sync1;
      en_r = st_ff.ext_read_phase_enable;

      // Register writes
      if (i_reg_wr) begin
         case (i_reg_addr)
            `SFXR_OFF_EXT_READ_COMMAND:
               nxt_st.ext_read_command = i_reg_wdata & `SFXR_MSK_COMMAND;
            `SFXR_OFF_EXT_READ_OPTION_BYTES:
               nxt_st.ext_read_option_bytes = i_reg_wdata;
            `SFXR_OFF_EXT_READ_PHASE_ENABLE:
               nxt_st.ext_read_phase_enable = i_reg_wdata & `SFXR_MSK_PHASE_ENABLE;
            `SFXR_OFF_EXT_READ_DUMMY_CONFIG:
               nxt_st.ext_read_dummy_config = i_reg_wdata & `SFXR_MSK_DUMMY_CONFIG;
            `SFXR_OFF_SERIAL_BIT_RATE:
               nxt_st.serial_bit_rate = i_reg_wdata & `SFXR_MSK_BIT_RATE;
            `SFXR_OFF_MODE_CONTROL:
               nxt_st.direct = i_reg_wdata[0];
            `SFXR_OFF_ERASE_ADDR:
               nxt_st.erase_addr = i_reg_wdata[`SFXR_F_ERASE_ADDR];
            default: ;
         endcase
      end

      // Sequences start only from direct mode, engine idle
      if (i_reg_wr && i_reg_addr == `SFXR_OFF_SEQ_START && st_ff.direct
          && st_ff.sq == SQ_IDLE && i_reg_wdata[`SFXR_F_SEQ_CODE] != 2'h0) begin
         nxt_st.go = 1'b1;
         nxt_st.after = (i_reg_wdata[`SFXR_F_SEQ_CODE] == `SFXR_SEQ_ERASE) ?
                        SQ_ERASE : SQ_WR_STATUS;
         nxt_st.sq = (i_reg_wdata[`SFXR_F_SEQ_CODE] == `SFXR_SEQ_POLL) ?
                     SQ_POLL : SQ_WR_ENABLE;
      end

      // Register reads
      nxt_st.rdata = 32'h0;
      if (i_reg_rd) begin
         case (i_reg_addr)
            `SFXR_OFF_EXT_READ_COMMAND:      nxt_st.rdata = st_ff.ext_read_command;
            `SFXR_OFF_EXT_READ_OPTION_BYTES: nxt_st.rdata = st_ff.ext_read_option_bytes;
            `SFXR_OFF_EXT_READ_PHASE_ENABLE: nxt_st.rdata = st_ff.ext_read_phase_enable;
            `SFXR_OFF_EXT_READ_DUMMY_CONFIG: nxt_st.rdata = st_ff.ext_read_dummy_config;
            `SFXR_OFF_SERIAL_BIT_RATE:       nxt_st.rdata = st_ff.serial_bit_rate;
            `SFXR_OFF_MODE_CONTROL:          nxt_st.rdata = {31'h0, st_ff.direct};
            `SFXR_OFF_ERASE_ADDR:            nxt_st.rdata = {8'h0, st_ff.erase_addr};
            `SFXR_OFF_ENGINE_STATUS:
               nxt_st.rdata = {22'h0, st_ff.sq != SQ_IDLE, st_ff.phase != PH_IDLE,
                               st_ff.flash_sr};
            default:                         nxt_st.rdata = 32'h0;
         endcase
      end

      // Direct transaction shape follows the sequencer step
      d_addr = st_ff.sq == SQ_ERASE;
      d_read = st_ff.sq == SQ_POLL;
      d_wr   = st_ff.sq == SQ_WR_STATUS;
      opc_seq = d_addr ? `SFXR_OP_SECTOR_ERASE : d_read ? `SFXR_OP_READ_STATUS :
                d_wr ? `SFXR_OP_WRITE_STATUS : `SFXR_OP_WRITE_ENABLE;

      go_mem = i_mem_rd && st_ff.ready;
      start  = go_mem || (st_ff.go && st_ff.phase == PH_IDLE && st_ff.sq != SQ_IDLE);
      x      = start ? go_mem : st_ff.ext;
      m      = go_mem ? i_mem_addr : st_ff.maddr;
      cur    = start ? 3'd0 : 3'(st_ff.phase);

      // ----------------------------------------------------------------
      // Phase table: enable, lane width, bytes, load value
      // ----------------------------------------------------------------
      en[0] = 1'b0;
      en[1] = x ? en_r.opcode_phase_on : 1'b1;
      en[2] = x & en_r.second_opcode_on;
      en[3] = x ? (en_r.addr_byte_select != 4'h0) : d_addr;
      en[4] = x & (en_r.option_byte_select != 4'h0);
      en[5] = x & en_r.dummy_phase_on;
      en[6] = x | d_read | d_wr;
      lw[0] = 2'b00;
      lw[1] = x ? en_r.opcode_lane_width : 2'b00;
      lw[2] = en_r.second_opcode_lane_width;
      lw[3] = x ? en_r.addr_lane_width : 2'b00;
      lw[4] = en_r.option_lane_width;
      lw[5] = st_ff.ext_read_dummy_config[`SFXR_F_DUMMY_LANE_WIDTH];
      lw[6] = x ? en_r.read_lane_width : 2'b00;
      nb[0] = 3'd0;
      nb[1] = 3'd1;
      nb[2] = 3'd1;
      nb[3] = x ? pc4(en_r.addr_byte_select) : 3'd3;
      nb[4] = pc4(en_r.option_byte_select);
      nb[5] = 3'd0;
      nb[6] = x ? 3'd4 : (d_wr ? 3'd2 : 3'd1);
      ld[0] = 32'h0;
      ld[1] = {x ? st_ff.ext_read_command[`SFXR_F_OPCODE] : opc_seq, 24'h0};
      ld[2] = {st_ff.ext_read_command[`SFXR_F_SECOND_OPCODE], 24'h0};
      ld[3] = x ? (m << {3'd4 - nb[3], 3'b000}) : {st_ff.erase_addr, 8'h00};
      ld[4] = st_ff.ext_read_option_bytes;
      ld[5] = 32'h0;
      // Status byte with quad set and all protection clear, then config byte
      ld[6] = d_wr ? {`SFXR_SR_SETUP, `SFXR_CR_SETUP, 16'h0} : 32'h0;

      // Nearest enabled phase after the current one; 0 ends the transfer
      np = 3'd0;
      for (int k = 6; k >= 1; k--) begin
         if (en[k] && 3'(k) > cur) begin
            np = 3'(k);
         end
      end

      // ----------------------------------------------------------------
      // Serial clock and shifter
      // ----------------------------------------------------------------
      rv   = (st_ff.serial_bit_rate[`SFXR_F_RATE_VALUE] == 8'h0) ? 8'h1 :
             st_ff.serial_bit_rate[`SFXR_F_RATE_VALUE];
      half = 14'(rv) << {st_ff.serial_bit_rate[`SFXR_F_RATE_DIVIDER], 1'b0};
      rd_ph = cur == 3'd6 && (st_ff.ext || d_read);
      inb = lw[cur][1] ? st_ff.sync2 :
            (lw[cur][0] ? {2'b00, st_ff.sync2[1:0]} : {3'b000, st_ff.sync2[1]});
      sh = (st_ff.sr << (3'd1 << lsh(lw[cur]))) | {28'h0, inb & {4{rd_ph}}};
      fall = st_ff.phase != PH_IDLE && st_ff.div == 14'h0 && st_ff.sck;

      if (st_ff.phase != PH_IDLE) begin
         if (st_ff.div != 14'h0) begin
            nxt_st.div = st_ff.div - 14'd1;
         end else begin
            nxt_st.div = half - 14'd1;
            nxt_st.sck = ~st_ff.sck;
            // Falling edge moves out the next bits and takes in read bits
            if (st_ff.sck) begin
               nxt_st.sr  = sh;
               nxt_st.cnt = st_ff.cnt - 6'd1;
            end
         end
      end

      if (start) begin
         nxt_st.ext = go_mem;
         nxt_st.go  = 1'b0;
         if (go_mem) begin
            nxt_st.maddr = i_mem_addr;
         end
      end

      if (start || (fall && st_ff.cnt == 6'd1)) begin
         nxt_st.div = half - 14'd1;
         nxt_st.sck = 1'b0;
         if (np != 3'd0) begin
            nxt_st.phase = sfxr_phase_type'(np);
            nxt_st.cs_n  = 1'b0;
            nxt_st.sr    = ld[np];
            nxt_st.cnt   = (np == 3'd5) ?
                           6'(st_ff.ext_read_dummy_config[`SFXR_F_DUMMY_COUNT]) + 6'd1 :
                           6'({nb[np], 3'b000}) >> lsh(lw[np]);
         end else begin
            nxt_st.phase = PH_IDLE;
            nxt_st.cs_n  = 1'b1;
            if (st_ff.ext) begin
               // First byte received lands in bits 31:24
               nxt_st.mem_rdata = sh;
               nxt_st.mem_valid = 1'b1;
            end else begin
               unique case (st_ff.sq)
                  SQ_WR_ENABLE: begin
                     nxt_st.sq = st_ff.after;
                     nxt_st.go = 1'b1;
                  end
                  SQ_WR_STATUS, SQ_ERASE: begin
                     nxt_st.sq = SQ_POLL;
                     nxt_st.go = 1'b1;
                  end
                  SQ_POLL: begin
                     nxt_st.flash_sr = sh[7:0];
                     // Busy keeps polling; no limit, the flash must finish
                     nxt_st.sq = sh[`SFXR_WIP_BIT] ? SQ_POLL : SQ_IDLE;
                     nxt_st.go = sh[`SFXR_WIP_BIT];
                  end
                  SQ_IDLE: ;
               endcase
            end
         end
      end

      // ----------------------------------------------------------------
      // Pin drive, registered with the phase it belongs to
      // ----------------------------------------------------------------
      wn = lw[3'(nxt_st.phase)];
      drive = nxt_st.phase != PH_IDLE && nxt_st.phase != PH_DUMMY &&
              !(nxt_st.phase == PH_DATA && (x || d_read));
      nxt_st.io_oe = drive ? (wn[1] ? 4'hf : (wn[0] ? 4'h3 : 4'h1)) : 4'h0;
      nxt_st.io_out = wn[1] ? nxt_st.sr[31:28] :
                      (wn[0] ? {2'b00, nxt_st.sr[31:30]} : {3'b000, nxt_st.sr[31]});
      nxt_st.ready = !nxt_st.direct && nxt_st.phase == PH_IDLE &&
                     nxt_st.sq == SQ_IDLE && !nxt_st.go;
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st_ff <= '{ext_read_command: `SFXR_RST_COMMAND,
                    ext_read_phase_enable: sfxr_ena_type'(`SFXR_RST_PHASE_ENABLE),
                    ext_read_dummy_config: `SFXR_RST_DUMMY_CONFIG,
                    serial_bit_rate: `SFXR_RST_BIT_RATE,
                    sq: SQ_IDLE, after: SQ_IDLE, phase: PH_IDLE,
                    cs_n: 1'b1, ready: 1'b1, default: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_reg_rdata  = st_ff.rdata;
   assign o_mem_ready  = st_ff.ready;
   assign o_mem_rdata  = st_ff.mem_rdata;
   assign o_mem_valid  = st_ff.mem_valid;
   assign o_spi_sclk   = st_ff.sck;
   assign o_spi_cs_n   = st_ff.cs_n;
   assign o_spi_io_out = st_ff.io_out;
   assign o_spi_io_oe  = st_ff.io_oe;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_sys_rst);

   sequence s_write_enable_command_end;
      st_ff.sq == SQ_WR_ENABLE && st_ff.phase != PH_IDLE ##1 st_ff.phase == PH_IDLE;
   endsequence

   sequence s_dummy_entry;
      st_ff.phase != PH_DUMMY ##1 st_ff.phase == PH_DUMMY;
   endsequence

   AST_MEM_TAKEN: assert property (i_mem_rd && o_mem_ready |=> !o_spi_cs_n
      && !o_mem_ready) else $error("mapped read not started");
   AST_CMD_CODE: assert property (go_mem && en_r.opcode_phase_on |=>
      st_ff.phase == PH_CMD && st_ff.sr[31:24] == st_ff.ext_read_command[`SFXR_F_OPCODE])
      else $error("command phase missing or wrong opcode");
   AST_CMD_SINGLE: assert property (st_ff.ext && st_ff.phase == PH_CMD
      && st_ff.ext_read_phase_enable.opcode_lane_width == 2'b00 |-> o_spi_io_oe == 4'h1)
      else $error("command not on one line");
   AST_ADDR_QUAD: assert property (st_ff.ext && st_ff.phase == PH_ADDR
      && st_ff.ext_read_phase_enable.addr_lane_width == 2'b10
      |-> o_spi_io_oe == 4'hf && o_spi_io_out == st_ff.sr[31:28])
      else $error("address not on four lines");
   AST_READ_RELEASE: assert property (st_ff.ext && st_ff.phase inside {PH_DUMMY, PH_DATA}
      |-> o_spi_io_oe == 4'h0) else $error("lanes driven during dummy or read");
   AST_DUMMY_LEN: assert property (s_dummy_entry |-> st_ff.cnt ==
      6'(st_ff.ext_read_dummy_config[`SFXR_F_DUMMY_COUNT]) + 6'd1)
      else $error("wrong dummy cycle count");
   AST_SCK_HALF: assert property (st_ff.phase != PH_IDLE && $past(st_ff.phase) != PH_IDLE
      && st_ff.serial_bit_rate == 32'h00000100 |-> o_spi_sclk != $past(o_spi_sclk))
      else $error("serial clock not half rate");
   AST_WRITE_ENABLE_COMMAND_BEFORE: assert property (s_write_enable_command_end |-> st_ff.go
      && st_ff.sq == st_ff.after) else $error("write enable not followed by its step");
   AST_POLL_READY: assert property (st_ff.sq == SQ_POLL && fall && st_ff.cnt == 6'd1
      && st_ff.phase == PH_DATA |=> (st_ff.sq == SQ_IDLE) == !st_ff.flash_sr[0])
      else $error("ready poll decision wrong");
   AST_DIRECT_NO_MEM: assert property (st_ff.direct |-> !o_mem_ready)
      else $error("mapped read offered in direct mode");

endmodule

// *** logic/sfxr_cfg.svh ***
// Register map, field positions, reset values and flash opcodes
`ifndef SFXR_CFG_SVH
`define SFXR_CFG_SVH
// Register byte offsets
`define SFXR_OFF_EXT_READ_COMMAND      8'h00
`define SFXR_OFF_EXT_READ_OPTION_BYTES 8'h04
`define SFXR_OFF_EXT_READ_PHASE_ENABLE 8'h08
`define SFXR_OFF_EXT_READ_DUMMY_CONFIG 8'h0c
`define SFXR_OFF_SERIAL_BIT_RATE       8'h10
`define SFXR_OFF_MODE_CONTROL          8'h14
`define SFXR_OFF_SEQ_START             8'h18
`define SFXR_OFF_ERASE_ADDR            8'h1c
`define SFXR_OFF_ENGINE_STATUS         8'h20
// Field positions
`define SFXR_F_OPCODE                  23:16
`define SFXR_F_SECOND_OPCODE           7:0
`define SFXR_F_DUMMY_LANE_WIDTH        17:16
`define SFXR_F_DUMMY_COUNT             2:0
`define SFXR_F_RATE_VALUE              15:8
`define SFXR_F_RATE_DIVIDER            1:0
`define SFXR_F_SEQ_CODE                1:0
`define SFXR_F_ERASE_ADDR              23:0
`define SFXR_WIP_BIT                   0
// Writable bit masks; reserved bits read as zero
`define SFXR_MSK_COMMAND               32'h00ff00ff
`define SFXR_MSK_PHASE_ENABLE          32'hf333dff0
`define SFXR_MSK_DUMMY_CONFIG          32'h00030007
`define SFXR_MSK_BIT_RATE              32'h0000ff03
// Reset values: quad I/O read profile
`define SFXR_RST_COMMAND               32'h00eb0000
`define SFXR_RST_PHASE_ENABLE          32'h0222c780
`define SFXR_RST_DUMMY_CONFIG          32'h00000005
`define SFXR_RST_BIT_RATE              32'h00000100
// Sequence codes
`define SFXR_SEQ_SETUP                 2'h1
`define SFXR_SEQ_ERASE                 2'h2
`define SFXR_SEQ_POLL                  2'h3
// Flash opcodes and setup values
`define SFXR_OP_WRITE_ENABLE           8'h06
`define SFXR_OP_WRITE_STATUS           8'h01
`define SFXR_OP_READ_STATUS            8'h05
`define SFXR_OP_SECTOR_ERASE           8'h20
`define SFXR_SR_SETUP                  8'h40
`define SFXR_CR_SETUP                  8'h80
`endif

// *** logic/sfxr_pkg.sv ***
// Types of the flash read engine
package sfxr_pkg;
   typedef enum logic [2:0] {
      PH_IDLE, PH_CMD, PH_SECOND_OPCODE, PH_ADDR, PH_OPT, PH_DUMMY, PH_DATA
   } sfxr_phase_type;
   typedef enum logic [2:0] {
      SQ_IDLE, SQ_WR_ENABLE, SQ_WR_STATUS, SQ_ERASE, SQ_POLL
   } sfxr_seq_type;
   typedef struct packed {
      logic [1:0] opcode_lane_width;
      logic [1:0] second_opcode_lane_width;
      logic [1:0] rsv0;
      logic [1:0] addr_lane_width;
      logic [1:0] rsv1;
      logic [1:0] option_lane_width;
      logic [1:0] rsv2;
      logic [1:0] read_lane_width;
      logic       dummy_phase_on;
      logic       opcode_phase_on;
      logic       rsv3;
      logic       second_opcode_on;
      logic [3:0] addr_byte_select;
      logic [3:0] option_byte_select;
      logic [3:0] rsv4;
   } sfxr_ena_type;
   typedef struct packed {
      logic [31:0]    ext_read_command;
      logic [31:0]    ext_read_option_bytes;
      sfxr_ena_type   ext_read_phase_enable;
      logic [31:0]    ext_read_dummy_config;
      logic [31:0]    serial_bit_rate;
      logic           direct;
      logic [23:0]    erase_addr;
      sfxr_seq_type   sq;
      sfxr_seq_type   after;
      logic           go;
      logic           ext;
      logic [31:0]    maddr;
      sfxr_phase_type phase;
      logic [31:0]    sr;
      logic [5:0]     cnt;
      logic [13:0]    div;
      logic           sck;
      logic           cs_n;
      logic [3:0]     io_out;
      logic [3:0]     io_oe;
      logic [3:0]     sync1;
      logic [3:0]     sync2;
      logic [31:0]    rdata;
      logic [31:0]    mem_rdata;
      logic           mem_valid;
      logic           ready;
      logic [7:0]     flash_sr;
   } sfxr_state_type;
endpackage

// *** testbench/sfxr_flash_model.sv ***
// Behavioural serial flash standing on the far side of the read engine
`timescale 1ns/1ps
module sfxr_flash_model #(parameter int BUSY_POLLS = 3) (
   input  wire logic [0:0]  i_sclk,   // Serial clock, mode 0
   input  wire logic [0:0]  i_cs_n,   // Chip select, active low
   input  wire logic [3:0]  i_io,     // Resolved lane levels
   output logic      [3:0]  o_io,     // Lanes as driven by the flash
   output logic      [7:0]  o_sr,     // Status byte
   output logic      [7:0]  o_cr,     // Configuration byte
   output logic      [7:0]  o_cmd,    // Opcode of the current frame
   output logic      [23:0] o_addr,   // Last address taken
   output logic      [7:0]  o_opt,    // Option byte on four lanes
   output int               o_cnt,    // Serial clocks in the frame
   output int               o_erases, // Accepted sector erases
   output int               o_polls   // Status reads served
);
   logic [63:0] sh;
   logic [5:0]  bp;
   logic        write_enable_latch;
   int          busy;
   wire  [31:0] word = {o_addr, 8'hc3};
   assign o_sr = {bp, write_enable_latch, busy != 0};
   initial begin
      {o_io, o_cr, o_cmd, o_addr, o_opt, sh, write_enable_latch} = '0;
      bp = 6'h0f;
      busy = 0;
   end
   always @(negedge i_cs_n) begin
      o_cnt = 0;
      sh = '0;
   end
   always @(posedge i_sclk) if (!i_cs_n) begin
      o_cnt++;
      sh = {sh[62:0], i_io[0]};
      if (o_cnt == 8) o_cmd = sh[7:0];
      if (o_cmd == 8'heb && o_cnt > 8 && o_cnt < 15) o_addr = {o_addr[19:0], i_io};
      if (o_cmd == 8'heb && o_cnt > 14 && o_cnt < 17) o_opt = {o_opt[3:0], i_io};
      // Lanes nobody reads keep toggling so a stale value is never mistaken for data.
      // Read bits launch one serial clock ahead: the engine sees its pins two system
      // clocks late through the synchroniser, which at clk/2 is a whole bit time.
      o_io = ~o_io;
      if (o_cmd == 8'heb && o_cnt > 21 && o_cnt < 30) o_io = word[31 - 4 * (o_cnt - 22) -: 4];
      if (o_cmd == 8'h05 && o_cnt > 7 && o_cnt < 16) o_io[1] = o_sr[15 - o_cnt];
   end
   always @(posedge i_cs_n) begin
      o_io = ~o_io;
      if (o_cnt >= 8) begin
         case (o_cmd)
            8'h06: if (o_cnt == 8) write_enable_latch = 1'b1;
            8'h01: if (o_cnt == 24 && write_enable_latch) begin
               bp = sh[15:10];
               o_cr = sh[7:0];
               write_enable_latch = 1'b0;
            end
            8'h20: if (o_cnt == 32 && write_enable_latch) begin
               if (bp[3:0] == 4'h0) begin
                  o_erases++;
                  busy = BUSY_POLLS;
                  o_addr = sh[23:0];
               end
               write_enable_latch = 1'b0;
            end
            8'h05: begin
               o_polls++;
               if (busy > 0) busy--;
            end
            default: ;
         endcase
      end
   end
endmodule

// *** testbench/test_spi_flash_xip_read_setup.sv ***
// Self-checking bench for the mapped read engine and flash sequencer
`timescale 1ns/1ps
`include "sfxr_cfg.svh"
module test_spi_flash_xip_read_setup;
   logic        i_sys_clk = 1'b0;
   logic        i_sys_rst = 1'b1;
   logic [7:0]  reg_addr  = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr    = 1'b0;
   logic        reg_rd    = 1'b0;
   logic        mem_rd    = 1'b0;
   logic [31:0] mem_addr  = 32'h0;
   logic [31:0] v;
   wire  [31:0] reg_rdata, mem_rdata;
   wire         mem_ready, mem_valid, sclk, cs_n;
   wire  [3:0]  io_out, io_oe, fl_io, io;
   wire  [7:0]  fl_sr, fl_cr, fl_cmd, fl_opt;
   wire  [23:0] fl_addr;
   int          fl_cnt, fl_erases, fl_polls, p0, f0;
   int          bad_count = 0, samples_checked = 0, cycles = 0, frames = 0;
   assign io = (io_oe & io_out) | (~io_oe & fl_io);
   always #2.5 i_sys_clk = ~i_sys_clk;
   always @(negedge cs_n) frames++;
   sfxr_top i_dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_reg_addr(reg_addr),
      .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
      .i_mem_rd(mem_rd), .i_mem_addr(mem_addr), .o_mem_ready(mem_ready),
      .o_mem_rdata(mem_rdata), .o_mem_valid(mem_valid), .o_spi_sclk(sclk), .o_spi_cs_n(cs_n),
      .o_spi_io_out(io_out), .o_spi_io_oe(io_oe), .i_spi_io_in(io));
   sfxr_flash_model #(.BUSY_POLLS(3)) i_flash (.i_sclk(sclk), .i_cs_n(cs_n), .i_io(io),
      .o_io(fl_io), .o_sr(fl_sr), .o_cr(fl_cr), .o_cmd(fl_cmd), .o_addr(fl_addr),
      .o_opt(fl_opt), .o_cnt(fl_cnt), .o_erases(fl_erases), .o_polls(fl_polls));
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Hang guard: the whole run needs well under this many cycles
   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         tally_and_finish;
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge i_sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge i_sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // One mapped read; the high time of the serial clock shows the rate
   task automatic mread(input logic [31:0] a, input int half);
      int n, hi;
      n = 0;
      hi = 0;
      @(posedge i_sys_clk);
      mem_addr <= a;
      mem_rd <= 1'b1;
      @(posedge i_sys_clk);
      mem_rd <= 1'b0;
      do begin
         @(posedge i_sys_clk);
         #1 n++;
         if (sclk === 1'b1) hi++;
      end while (mem_valid !== 1'b1 && n < 1000);
      check(n < 1000, 1'b1);
      check(mem_rdata, {a[23:0], 8'hc3});
      check(fl_cmd, 8'heb);
      check(fl_opt, 8'ha5);
      check(fl_cnt, 30);
      check(hi, 30 * half);
   endtask
   task automatic run_seq(input logic [1:0] code);
      int n;
      n = 0;
      wr(`SFXR_OFF_SEQ_START, {30'h0, code});
      repeat (3) @(posedge i_sys_clk);
      do begin
         rd(`SFXR_OFF_ENGINE_STATUS, v);
         n++;
      end while (v[9] !== 1'b0 && n < 2000);
      check(n < 2000, 1'b1);
   endtask
   initial begin
      repeat (4) @(posedge i_sys_clk);
      i_sys_rst <= 1'b0;
      rd(`SFXR_OFF_EXT_READ_COMMAND, v);
      check(v, 32'h00eb0000);
      rd(`SFXR_OFF_EXT_READ_PHASE_ENABLE, v);
      check(v, 32'h0222c780);
      rd(`SFXR_OFF_EXT_READ_DUMMY_CONFIG, v);
      check(v, 32'h00000005);
      rd(`SFXR_OFF_SERIAL_BIT_RATE, v);
      check(v, 32'h00000100);
      wr(8'h30, 32'hffffffff);
      rd(8'h30, v);
      check(v, 32'h0);
      wr(`SFXR_OFF_EXT_READ_COMMAND, 32'hffebff00);
      rd(`SFXR_OFF_EXT_READ_COMMAND, v);
      check(v, 32'h00eb0000);
      wr(`SFXR_OFF_EXT_READ_OPTION_BYTES, 32'ha5000000);
      mread(32'h00123454, 1);
      wr(`SFXR_OFF_SERIAL_BIT_RATE, 32'h00000200);
      mread(32'h00fedcb8, 2);
      wr(`SFXR_OFF_SERIAL_BIT_RATE, 32'h00000100);
      // Sequence start in read mode and mapped reads in direct mode are both refused
      f0 = frames;
      wr(`SFXR_OFF_SEQ_START, {30'h0, `SFXR_SEQ_SETUP});
      wr(`SFXR_OFF_MODE_CONTROL, 32'h1);
      repeat (2) @(posedge i_sys_clk);
      check(mem_ready, 1'b0);
      mem_rd <= 1'b1;
      @(posedge i_sys_clk);
      mem_rd <= 1'b0;
      repeat (80) @(posedge i_sys_clk);
      check(frames, f0);
      wr(`SFXR_OFF_ERASE_ADDR, 32'h00012000);
      run_seq(`SFXR_SEQ_ERASE);
      check(fl_erases, 0);
      check(v[7:0], 8'h3c);
      run_seq(`SFXR_SEQ_SETUP);
      check(fl_sr, 8'h40);
      check(fl_cr, 8'h80);
      p0 = fl_polls;
      run_seq(`SFXR_SEQ_ERASE);
      check(fl_erases, 1);
      check(fl_addr, 24'h012000);
      check(fl_polls - p0, 4);
      check(v[7:0], 8'h40);
      wr(`SFXR_OFF_MODE_CONTROL, 32'h0);
      repeat (2) @(posedge i_sys_clk);
      check(mem_ready, 1'b1);
      mread(32'h00000010, 1);
      tally_and_finish;
   end
endmodule
